// [design/spfc_regs.svh]
// register map, field positions, reset values and timing figures of the serial port
`ifndef SPFC_REGS_SVH
`define SPFC_REGS_SVH
`define SPFC_CLK_HZ         20000000
`define SPFC_XON_PERIOD_MS  1000
`define SPFC_BUSY_SHORT_MS  200
`define SPFC_BUSY_LONG_MS   1000
`define SPFC_MIN_CLK_HZ     307200
`define SPFC_CHAR_XON       8'h11
`define SPFC_CHAR_XOFF      8'h13
`define SPFC_ADDR_CTRL      4'h0
`define SPFC_ADDR_STATUS    4'h4
`define SPFC_ADDR_RXDATA    4'h8
`define SPFC_ADDR_TXDATA    4'hc
`define SPFC_CFG_W          10
`define SPFC_CFG_RESET      10'h205
`define SPFC_ST_RX_FULL     0
`define SPFC_ST_TX_BUSY     1
`define SPFC_ST_BUSY        2
`define SPFC_ST_PERR        3
`define SPFC_ST_FERR        4
`define SPFC_ST_OVR         5
`endif

// [design/spfc_pkg.sv]
// types shared by the serial port with flow control
package spfc_pkg;
  typedef enum logic [1:0] {
    ready_at_space_level           = 2'h0,
    ready_at_mark_level            = 2'h1,
    inband_flow_only               = 2'h2,
    busy_line_plus_periodic_resume = 2'h3
  } spfc_flow_t;
  typedef enum logic [1:0] {
    spfc_par_none = 2'h0,
    spfc_par_even = 2'h1,
    spfc_par_odd  = 2'h2
  } spfc_par_t;
  typedef struct packed {
    logic       lang_hold;
    logic       busy_long;
    spfc_flow_t flow;
    spfc_par_t  parity;
    logic       seven_bits;
    logic [2:0] baud;
  } spfc_cfg_t;
  typedef enum logic [2:0] {
    spfc_idle   = 3'h0,
    spfc_start  = 3'h1,
    spfc_data   = 3'h2,
    spfc_parity = 3'h3,
    spfc_stop   = 3'h4
  } spfc_state_t;
endpackage

// [design/spfc_top.sv]
// serial port with ready/busy and xon/xoff flow control, avalon-mm register slave
`timescale 1ns/10ps
`default_nettype none
`include "spfc_regs.svh"
module spfc_top #(
  parameter int unsigned CLK_HZ     = `SPFC_CLK_HZ,
  parameter int unsigned XON_CYC    = `SPFC_CLK_HZ / 1000 * `SPFC_XON_PERIOD_MS,
  parameter int unsigned BUSY_S_CYC = `SPFC_CLK_HZ / 1000 * `SPFC_BUSY_SHORT_MS,
  parameter int unsigned BUSY_L_CYC = `SPFC_CLK_HZ / 1000 * `SPFC_BUSY_LONG_MS
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                ce_i,
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                rxd_i,
  output logic                     txd_o,
  output logic                     dtr_o,
  output logic                     rts_o,
  input  wire spfc_pkg::spfc_cfg_t nv_cfg_i,
  input  wire logic                nv_valid_i,
  output spfc_pkg::spfc_cfg_t      nv_cfg_o
);
  if (CLK_HZ < `SPFC_MIN_CLK_HZ || XON_CYC == 0 || BUSY_S_CYC == 0 || BUSY_L_CYC == 0) begin : g_chk
    $error("spfc_top: clock too slow or zero timing count");
  end

  spfc_pkg::spfc_cfg_t   cfg_q, cfg_d;
  logic                  load_q, load_d, ack_q, ack_d;
  logic [31:0]           rdata_q, rdata_d, bit_cyc;
  logic                  req, tx_wr, rx_pop, tx_take;
  logic                  perr_q, perr_d, ferr_q, ferr_d, ovr_q, ovr_d;
  spfc_pkg::spfc_state_t rx_st_q, rx_st_d, tx_st_q, tx_st_d;
  logic [31:0]           rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
  logic [3:0]            rx_bit_q, rx_bit_d, tx_bit_q, tx_bit_d;
  logic [7:0]            rx_sh_q, rx_sh_d, rx_data_q, rx_data_d, tx_sh_q, tx_sh_d;
  logic                  rx_full_q, rx_full_d, rx_par_q, rx_par_d, rx_done;
  logic                  tx_par_q, tx_par_d, txd_q, txd_d;
  logic                  busy_q, busy_d, xon_pend_q, xon_pend_d, xoff_pend_q, xoff_pend_d;
  logic [31:0]           hold_q, hold_d, per_q, per_d;
  logic                  hold_done, ctl_go;
  logic [3:0]            nbits;
  logic [7:0]            tx_byte, tx_char;

  // bit time from the selected rate; divisor rounds down
  always_comb begin
    case (cfg_q.baud)
      3'h0:    bit_cyc = CLK_HZ / 300;
      3'h1:    bit_cyc = CLK_HZ / 600;
      3'h2:    bit_cyc = CLK_HZ / 1200;
      3'h3:    bit_cyc = CLK_HZ / 2400;
      3'h4:    bit_cyc = CLK_HZ / 4800;
      3'h6:    bit_cyc = CLK_HZ / 19200;
      default: bit_cyc = CLK_HZ / 9600;
    endcase
  end
  assign nbits = cfg_q.seven_bits ? 4'h7 : 4'h8;

  // bus slave: one wait cycle, longer for a transmit-data write while the transmitter is occupied or a flow character is pending
  assign req     = avs_read_i | avs_write_i;
  assign tx_wr   = avs_write_i && avs_address_i == `SPFC_ADDR_TXDATA;
  assign tx_take = ack_q && tx_wr;
  assign rx_pop  = ack_q && avs_read_i && avs_address_i == `SPFC_ADDR_RXDATA;
  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o    = rdata_q;
  assign nv_cfg_o          = cfg_q;
  assign rts_o             = 1'b0;

  always_comb begin
    load_d  = 1'b0;
    cfg_d   = cfg_q;
    rdata_d = rdata_q;
    ack_d   = req & ~ack_q &
              ~(tx_wr & (tx_st_q != spfc_pkg::spfc_idle | xon_pend_q | xoff_pend_q));
    if (load_q && nv_valid_i) begin
      cfg_d = nv_cfg_i;
    end else if (ack_q && avs_write_i && avs_address_i == `SPFC_ADDR_CTRL) begin
      if (avs_byteenable_i[0]) cfg_d[7:0] = avs_writedata_i[7:0];
      if (avs_byteenable_i[1]) cfg_d[`SPFC_CFG_W-1:8] = avs_writedata_i[`SPFC_CFG_W-1:8];
    end
    if (ack_d && avs_read_i) begin
      rdata_d = 32'h0;
      case (avs_address_i)
        `SPFC_ADDR_CTRL:   rdata_d[`SPFC_CFG_W-1:0] = cfg_q;
        `SPFC_ADDR_STATUS: begin
          rdata_d[`SPFC_ST_RX_FULL] = rx_full_q;
          rdata_d[`SPFC_ST_TX_BUSY] = tx_st_q != spfc_pkg::spfc_idle;
          rdata_d[`SPFC_ST_BUSY]    = busy_q;
          rdata_d[`SPFC_ST_PERR]    = perr_q;
          rdata_d[`SPFC_ST_FERR]    = ferr_q;
          rdata_d[`SPFC_ST_OVR]     = ovr_q;
        end
        `SPFC_ADDR_RXDATA: rdata_d[7:0] = rx_data_q;
        default:           rdata_d = 32'h0;
      endcase
    end
  end

  // receiver: centre sampling gives the widest skew margin
  always_comb begin
    rx_st_d   = rx_st_q;
    rx_cnt_d  = rx_cnt_q;
    rx_bit_d  = rx_bit_q;
    rx_sh_d   = rx_sh_q;
    rx_par_d  = rx_par_q;
    rx_data_d = rx_data_q;
    rx_done   = 1'b0;
    perr_d    = perr_q;
    ferr_d    = ferr_q;
    ovr_d     = ovr_q;
    if (ack_q && avs_write_i && avs_address_i == `SPFC_ADDR_STATUS && avs_byteenable_i[0]) begin
      perr_d = perr_q & ~avs_writedata_i[`SPFC_ST_PERR];
      ferr_d = ferr_q & ~avs_writedata_i[`SPFC_ST_FERR];
      ovr_d  = ovr_q & ~avs_writedata_i[`SPFC_ST_OVR];
    end
    if (rx_cnt_q != 32'h0) rx_cnt_d = rx_cnt_q - 32'h1;
    case (rx_st_q)
      spfc_pkg::spfc_idle: if (!rxd_i) begin
        rx_st_d  = spfc_pkg::spfc_start;
        rx_cnt_d = bit_cyc >> 1;
      end
      spfc_pkg::spfc_start: if (rx_cnt_q == 32'h0) begin
        rx_st_d  = rxd_i ? spfc_pkg::spfc_idle : spfc_pkg::spfc_data;
        rx_cnt_d = bit_cyc - 32'h1;
        rx_bit_d = 4'h0;
        rx_sh_d  = 8'h0;
        rx_par_d = 1'b0;
      end
      spfc_pkg::spfc_data: if (rx_cnt_q == 32'h0) begin
        rx_sh_d  = {rxd_i, rx_sh_q[7:1]};
        rx_par_d = rx_par_q ^ rxd_i;
        rx_bit_d = rx_bit_q + 4'h1;
        rx_cnt_d = bit_cyc - 32'h1;
        if (rx_bit_q == nbits - 4'h1)
          rx_st_d = (cfg_q.parity == spfc_pkg::spfc_par_none) ? spfc_pkg::spfc_stop
                                                             : spfc_pkg::spfc_parity;
      end
      spfc_pkg::spfc_parity: if (rx_cnt_q == 32'h0) begin
        if ((rx_par_q ^ rxd_i) != (cfg_q.parity == spfc_pkg::spfc_par_odd)) perr_d = 1'b1;
        rx_cnt_d = bit_cyc - 32'h1;
        rx_st_d  = spfc_pkg::spfc_stop;
      end
      spfc_pkg::spfc_stop: if (rx_cnt_q == 32'h0) begin
        rx_st_d = spfc_pkg::spfc_idle;
        if (!rxd_i) begin
          ferr_d = 1'b1;
        end else begin
          rx_done   = 1'b1;
          rx_data_d = cfg_q.seven_bits ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
          if (rx_full_q && !rx_pop) ovr_d = 1'b1;
        end
      end
      default: rx_st_d = spfc_pkg::spfc_idle;
    endcase
    rx_full_d = rx_done | (rx_full_q & ~rx_pop); // a new char beats the pop
  end

  // busy indication and in-band flow characters
  assign hold_done = !cfg_q.lang_hold ||
                     hold_q >= (cfg_q.busy_long ? BUSY_L_CYC : BUSY_S_CYC);
  assign ctl_go = tx_st_q == spfc_pkg::spfc_idle && !(tx_wr && req);
  always_comb begin
    busy_d      = busy_q;
    hold_d      = busy_q ? hold_q + {31'h0, !hold_done} : 32'h0;
    per_d       = per_q;
    xon_pend_d  = xon_pend_q;
    xoff_pend_d = xoff_pend_q;
    if (rx_full_q && !busy_q) begin
      busy_d = 1'b1;
      if (cfg_q.flow == spfc_pkg::inband_flow_only) xoff_pend_d = 1'b1;
    end else if (!rx_full_q && busy_q && hold_done) begin
      busy_d = 1'b0;
      if (cfg_q.flow == spfc_pkg::inband_flow_only) xon_pend_d = 1'b1;
    end
    if (cfg_q.flow == spfc_pkg::busy_line_plus_periodic_resume && !busy_q) begin
      if (per_q >= XON_CYC - 1) begin
        per_d      = 32'h0;
        xon_pend_d = 1'b1;
      end else begin
        per_d = per_q + 32'h1;
      end
    end else begin
      per_d = 32'h0;
    end
    if (ctl_go && xoff_pend_q) xoff_pend_d = 1'b0;
    else if (ctl_go && xon_pend_q) xon_pend_d = 1'b0;
  end
  always_comb begin
    case (cfg_q.flow)
      spfc_pkg::ready_at_mark_level: dtr_o = ~busy_q;
      spfc_pkg::inband_flow_only:    dtr_o = 1'b0;
      default:                       dtr_o = busy_q;
    endcase
  end

  // transmitter
  assign tx_char = xoff_pend_q ? `SPFC_CHAR_XOFF : `SPFC_CHAR_XON;
  assign tx_byte = cfg_q.seven_bits ? {1'b0, avs_writedata_i[6:0]} : avs_writedata_i[7:0];
  assign txd_o   = txd_q;
  always_comb begin
    tx_st_d  = tx_st_q;
    tx_cnt_d = (tx_cnt_q != 32'h0) ? tx_cnt_q - 32'h1 : 32'h0;
    tx_bit_d = tx_bit_q;
    tx_sh_d  = tx_sh_q;
    tx_par_d = tx_par_q;
    txd_d    = txd_q;
    case (tx_st_q)
      spfc_pkg::spfc_idle: begin
        txd_d = 1'b1;
        if (tx_take || (ctl_go && (xon_pend_q || xoff_pend_q))) begin
          tx_sh_d  = tx_take ? tx_byte : tx_char;
          tx_par_d = (^tx_sh_d) ^ (cfg_q.parity == spfc_pkg::spfc_par_odd);
          tx_st_d  = spfc_pkg::spfc_start;
          tx_cnt_d = bit_cyc - 32'h1;
          txd_d    = 1'b0;
        end
      end
      spfc_pkg::spfc_start: if (tx_cnt_q == 32'h0) begin
        tx_st_d  = spfc_pkg::spfc_data;
        tx_bit_d = 4'h0;
        tx_cnt_d = bit_cyc - 32'h1;
        txd_d    = tx_sh_q[0];
      end
      spfc_pkg::spfc_data: if (tx_cnt_q == 32'h0) begin
        tx_sh_d  = {1'b0, tx_sh_q[7:1]};
        tx_bit_d = tx_bit_q + 4'h1;
        tx_cnt_d = bit_cyc - 32'h1;
        txd_d    = tx_sh_d[0];
        if (tx_bit_q == nbits - 4'h1) begin
          tx_st_d = (cfg_q.parity == spfc_pkg::spfc_par_none) ? spfc_pkg::spfc_stop
                                                             : spfc_pkg::spfc_parity;
          txd_d   = (cfg_q.parity == spfc_pkg::spfc_par_none) ? 1'b1 : tx_par_q;
        end
      end
      spfc_pkg::spfc_parity: if (tx_cnt_q == 32'h0) begin
        tx_st_d  = spfc_pkg::spfc_stop;
        tx_cnt_d = bit_cyc - 32'h1;
        txd_d    = 1'b1;
      end
      spfc_pkg::spfc_stop: if (tx_cnt_q == 32'h0) begin
        tx_st_d = spfc_pkg::spfc_idle;
        txd_d   = 1'b1;
      end
      default: tx_st_d = spfc_pkg::spfc_idle;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q     <= `SPFC_CFG_RESET;
      load_q    <= 1'b1;
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
      ovr_q     <= 1'b0;
      rx_st_q   <= spfc_pkg::spfc_idle;
      rx_cnt_q  <= 32'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h0;
      rx_par_q  <= 1'b0;
      rx_data_q <= 8'h0;
      rx_full_q <= 1'b0;
      busy_q    <= 1'b0;
      hold_q    <= 32'h0;
      per_q     <= 32'h0;
      xon_pend_q  <= 1'b0;
      xoff_pend_q <= 1'b0;
      tx_st_q   <= spfc_pkg::spfc_idle;
      tx_cnt_q  <= 32'h0;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 8'h0;
      tx_par_q  <= 1'b0;
      txd_q     <= 1'b1;
    end else if (ce_i) begin
      cfg_q     <= cfg_d;
      load_q    <= load_d;
      ack_q     <= ack_d;
      rdata_q   <= rdata_d;
      perr_q    <= perr_d;
      ferr_q    <= ferr_d;
      ovr_q     <= ovr_d;
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bit_q  <= rx_bit_d;
      rx_sh_q   <= rx_sh_d;
      rx_par_q  <= rx_par_d;
      rx_data_q <= rx_data_d;
      rx_full_q <= rx_full_d;
      busy_q    <= busy_d;
      hold_q    <= hold_d;
      per_q     <= per_d;
      xon_pend_q  <= xon_pend_d;
      xoff_pend_q <= xoff_pend_d;
      tx_st_q   <= tx_st_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_par_q  <= tx_par_d;
      txd_q     <= txd_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_rts_space: assert property (rts_o == 1'b0) else $error("rts left space");
  a_dtr_space_ready: assert property (cfg_q.flow == spfc_pkg::ready_at_space_level |-> dtr_o == busy_q) else $error("dtr polarity wrong");
  a_dtr_mark_ready: assert property (cfg_q.flow == spfc_pkg::ready_at_mark_level |-> dtr_o == !busy_q) else $error("dtr mark polarity wrong");
  a_busy_min_hold: assert property (ce_i && busy_q && !busy_d && cfg_q.lang_hold
    |-> hold_q >= (cfg_q.busy_long ? BUSY_L_CYC : BUSY_S_CYC)) else $error("busy released early");
  a_busy_follows_full: assert property (ce_i && rx_full_q && !busy_q |=> busy_q) else $error("busy not raised");
  a_tx_idle_mark: assert property (tx_st_q == spfc_pkg::spfc_idle && $past(tx_st_q) == spfc_pkg::spfc_idle |-> txd_o) else $error("idle line not mark");
  a_tx_start_space: assert property (tx_st_q == spfc_pkg::spfc_start |-> !txd_o) else $error("start bit not space");
  a_xon_periodic: assert property (ce_i && !xon_pend_q && xon_pend_d && cfg_q.flow != spfc_pkg::inband_flow_only |-> cfg_q.flow == spfc_pkg::busy_line_plus_periodic_resume && per_q == XON_CYC - 1) else $error("xon period wrong");
  a_rx_mid_sample: assert property (ce_i && rx_st_q == spfc_pkg::spfc_idle && !rxd_i |=> rx_cnt_q == bit_cyc >> 1) else $error("rx not centred");
  a_cfg_restore: assert property (ce_i && load_q && nv_valid_i |=> cfg_q == $past(nv_cfg_i)) else $error("config not restored");
  a_bit_len_reload: assert property (ce_i && tx_st_q == spfc_pkg::spfc_start && tx_cnt_q == 32'h0 |=> tx_cnt_q == bit_cyc - 32'h1) else $error("bit time wrong");
  c_rx_char: cover property (rx_done);
  c_busy_release: cover property (busy_q ##1 !busy_q);
  c_xon_sent: cover property (ctl_go && xon_pend_q);
endmodule // spfc_top
`default_nettype wire

// [dv/spfc_host_model.sv]
// host serial port model: frames characters onto the receive line, decodes the transmit line
`timescale 1ns/10ps
`default_nettype none
module spfc_host_model (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int unsigned bit_cyc = 41;
  int unsigned nbits   = 8;
  int unsigned par     = 0;
  logic [9:0]  rx_q[$];
  logic [9:0]  fr;
  logic [11:0] sh;
  initial rxd_o = 1'b1;
  // bc may differ from bit_cyc to skew the sender against the receiver
  task automatic send(input logic [7:0] d, input int unsigned bc, input logic bad);
    sh = 12'hfff;
    sh[0] = 1'b0;
    for (int i = 0; i < nbits; i++) sh[i+1] = d[i];
    if (par != 0) sh[nbits+1] = bad ^ (par == 2) ^ (^(d & (nbits == 7 ? 8'h7f : 8'hff)));
    for (int i = 0; i < nbits + 2 + (par != 0); i++) begin
      rxd_o <= sh[i];
      repeat (bc) @(posedge clk_i);
    end
  endtask
  // frame kept as {stop, parity, data}
  always begin
    @(posedge clk_i);
    if (txd_i === 1'b0) begin
      fr = 10'h0;
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (int i = 0; i <= nbits + (par != 0); i++) begin
        repeat (bit_cyc) @(posedge clk_i);
        if (i < nbits) fr[i] = txd_i;
        else if (par != 0 && i == nbits) fr[8] = txd_i;
        else fr[9] = txd_i;
      end
      rx_q.push_back(fr);
    end
  end
endmodule // spfc_host_model
`default_nettype wire

// [dv/spfc_top_tb_top.sv]
// self-checking bench of the serial port: bus, frames, flow control, stored settings
`timescale 1ns/10ps
`default_nettype none
`include "spfc_regs.svh"
module spfc_top_tb_top;
  localparam int unsigned HZ  = 400000;
  localparam int unsigned XON = 200;
  localparam int unsigned BS  = 60;
  localparam int unsigned BL  = 120;
  localparam logic [3:0]  ACT = `SPFC_ADDR_CTRL;
  localparam logic [3:0]  AST = `SPFC_ADDR_STATUS;
  localparam logic [3:0]  ARX = `SPFC_ADDR_RXDATA;
  localparam logic [3:0]  ATX = `SPFC_ADDR_TXDATA;
  logic                clk_i, reset_i, rd, wr, wait_o, rxd, txd, dtr, rts, nv_v;
  logic [3:0]          adr;
  logic [9:0]          f;
  logic [31:0]         wd, rdat, rv, c, d, x;
  logic [31:0]         seed = 32'h15;
  spfc_pkg::spfc_cfg_t nv_in, nv_out;
  int                  err_total = 0, samples_checked = 0, cyc = 0, n, t0;
  int unsigned         rate[7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
  spfc_top #(.CLK_HZ(HZ), .XON_CYC(XON), .BUSY_S_CYC(BS), .BUSY_L_CYC(BL)) u_spfc_top (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .rxd_i(rxd), .txd_o(txd), .dtr_o(dtr), .rts_o(rts),
    .nv_cfg_i(nv_in), .nv_valid_i(nv_v), .nv_cfg_o(nv_out));
  spfc_host_model u_spfc_host_model (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    n = 0;
    @(posedge clk_i);
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 4000);
    if (n >= 4000) chk(32'h0, 32'h1);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic setc(input logic [31:0] v);
    bus(1'b1, ACT, v);
    // new settings only show after the write edge has settled
    @(negedge clk_i);
    u_spfc_host_model.bit_cyc = HZ / rate[v[2:0]];
    u_spfc_host_model.nbits = v[3] ? 7 : 8;
    u_spfc_host_model.par = v[5:4];
  endtask
  task automatic take(input int lim);
    n = 0;
    while (u_spfc_host_model.rx_q.size() == 0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    f = 10'hx;
    if (u_spfc_host_model.rx_q.size() != 0) f = u_spfc_host_model.rx_q.pop_front();
  endtask
  task automatic hsend(input logic [7:0] v, input int unsigned bc, input logic bad);
    @(posedge clk_i);
    u_spfc_host_model.send(v, bc, bad);
  endtask
  initial begin
    {reset_i, rd, wr, adr, wd, nv_v, nv_in} = {1'b1, 49'h0};
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(1'b0, ACT, 0); chk(rv, 32'h205);
    chk(32'({txd, rts, dtr}), 32'h4);
    bus(1'b0, 4'h2, 0); chk(rv, 32'h0);
    for (int b = 0; b < 7; b++) begin
      setc(32'(b));
      bus(1'b1, ATX, 32'h55);
      chk(32'(nv_out), 32'(b));
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (txd !== 1'b0 && n < 100);
      n = 0;
      while (txd === 1'b0 && n < 2000) begin
        @(negedge clk_i);
        n++;
      end
      chk(n, HZ / rate[b]);
      take(12 * HZ / rate[b] + 50); chk(32'(f), 32'h255);
    end
    for (int s = 0; s < 2; s++) for (int p = 0; p < 3; p++) begin
      setc(32'h6 | (p << 4) | (s << 3));
      d = xs() & (s ? 32'h7f : 32'hff);
      bus(1'b1, ATX, d);
      x = (p == 0) ? 32'h0 : 32'((p == 2) ^ (^d));
      take(300); chk(32'(f), {22'h0, 1'b1, x[0], d[7:0]});
      d = xs() & (s ? 32'h7f : 32'hff);
      hsend(d[7:0], 20, 1'b0);
      bus(1'b0, AST, 0); chk(rv & 32'h3f, 32'h5);
      bus(1'b0, ARX, 0); chk(rv & 32'hff, d);
    end
    setc(32'h16);
    hsend(8'h3c, 20, 1'b1);
    bus(1'b0, AST, 0); chk(rv & 32'h8, 32'h8);
    bus(1'b0, ARX, 0); chk(rv & 32'hff, 32'h3c);
    bus(1'b1, AST, 32'h8);
    bus(1'b0, AST, 0); chk(rv & 32'h8, 32'h0);
    setc(32'h5);
    for (int k = 40; k < 43; k += 2) begin
      d = xs() & 32'hff;
      hsend(d[7:0], k, 1'b0);
      bus(1'b0, ARX, 0); chk(rv & 32'hff, d);
    end
    for (int m = 0; m < 4; m++) begin
      setc(32'h6 | (m << 6));
      u_spfc_host_model.rx_q.delete();
      chk(32'(dtr), 32'(m == 1));
      hsend(8'h41, 20, 1'b0);
      chk(32'(dtr), 32'(m == 0 || m == 3));
      if (m == 2) take(300);
      if (m == 2) chk(32'(f), 32'h213);
      bus(1'b0, ARX, 0);
      bus(1'b0, AST, 0); chk(32'(dtr), 32'(m == 1));
      if (m == 2) take(300);
      if (m == 2) chk(32'(f), 32'h211);
    end
    setc(32'hc6);
    u_spfc_host_model.rx_q.delete();
    take(XON + 300);
    t0 = $time;
    take(XON + 300); chk(32'(f), 32'h211);
    n = ($time - t0) / 50;
    chk(32'(n + 2 >= XON && n <= XON + 2), 32'h1);
    hsend(8'h42, 20, 1'b0);
    repeat (250) @(posedge clk_i);
    u_spfc_host_model.rx_q.delete();
    repeat (XON + 50) @(posedge clk_i);
    chk(u_spfc_host_model.rx_q.size(), 32'h0);
    bus(1'b0, ARX, 0);
    for (int b = 0; b < 2; b++) begin
      setc(32'h206 | (b << 8));
      hsend(8'h20, 20, 1'b0);
      t0 = $time;
      bus(1'b0, ARX, 0);
      while (dtr !== 1'b0 && ($time - t0) < 20000) @(posedge clk_i);
      n = ($time - t0) / 50;
      chk(32'(n + 10 >= (b ? BL : BS) && n <= (b ? BL : BS) + 20), 32'h1);
    end
    c = 32'h1d5;
    nv_in <= spfc_pkg::spfc_cfg_t'(c[9:0]);
    nv_v <= 1'b1;
    reset_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(1'b0, ACT, 0); chk(rv, c);
    chk(32'(nv_out), c);
    close_out();
  end
endmodule // spfc_top_tb_top
`default_nettype wire
